// ===== src/ivlpc_top.sv
// Interrupt vector selection, reset sources and low-power mode sequencing.
`timescale 1ns/1ns
`include "ivlpc_cfg.svh"
module ivlpc_top (
   // Clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst_n,
   // Reset causes
   input  wire logic                  ext_reset_event,
   input  wire logic                  watchdog_expire,
   input  wire logic                  flash_key_violation,
   input  wire logic                  fetch_valid,
   input  wire ivlpc_pkg::ivlpc_word_t fetch_addr,
   // Non-maskable sources and their enables
   input  wire logic                  ext_nmi_flag,
   input  wire logic                  osc_fault_flag,
   input  wire logic                  flash_access_violation_flag,
   input  wire logic                  ext_nmi_enable,
   input  wire logic                  osc_fault_enable,
   input  wire logic                  flash_access_violation_enable,
   // Maskable sources
   input  wire logic                  mailbox_out_flag,
   input  wire logic                  mailbox_in_flag,
   input  wire logic                  converter_overflow_flag,
   input  wire logic                  converter_result_flag,
   input  wire logic                  watchdog_flag,
   input  wire logic                  serial_rx_flag,
   input  wire logic                  serial_tx_flag,
   input  wire logic                  compare_match_flag,
   input  wire logic                  timer_overflow_flag,
   input  wire logic [7:0]            port_one_pin_flags,
   input  wire logic [7:0]            port_two_pin_flags,
   input  wire logic                  basic_tick_flag,
   // Maskable enables
   input  wire logic [15:0]           slot_enable,
   input  wire logic                  watchdog_irq_enable,
   input  wire logic                  watchdog_interval_mode,
   input  wire logic                  global_irq_enable,
   // CPU side
   input  wire logic                  mode_wr,
   input  wire ivlpc_pkg::ivlpc_mode_e mode_sel,
   input  wire logic                  irq_return,
   input  wire logic                  vec_fetch_valid,
   input  wire ivlpc_pkg::ivlpc_word_t vec_fetch_data,
   output logic                       vec_fetch_req,
   output ivlpc_pkg::ivlpc_word_t     vec_fetch_addr,
   output logic                       pc_load,
   output ivlpc_pkg::ivlpc_word_t     pc_value,
   output ivlpc_pkg::ivlpc_slot_t     taken_slot,
   output logic                       taken_pulse,
   output logic                       sys_reset,
   output ivlpc_pkg::ivlpc_mode_e     cur_mode,
   // Clock enables
   output logic                       cpu_halt,
   output logic                       aclk_run,
   output logic                       sub_main_clock_run,
   output logic                       mclk_avail,
   output logic                       loop_ctrl_run,
   output logic                       oscillator_clock_run,
   output logic                       dc_gen_on,
   output logic                       xtal_run
);
   import ivlpc_pkg::*;

   // ==========================================
   // Reset synchroniser
   logic         rst_meta_r;
   logic         rst_s_n;
   ivlpc_if      bus ();

   // Release is delayed two edges; assertion stays asynchronous.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_r <= 1'b0;
         rst_s_n    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_s_n    <= rst_meta_r;
      end
   end

   // ==========================================
   // Request gathering
   logic         illegal_fetch;
   logic         reset_cause;
   logic         nmi_req;
   logic         wdt_req;
   logic [15:0]  mask_req;
   logic [15:0]  slot_req;
   ivlpc_state_e state_r;
   ivlpc_mode_e  mode_r;
   ivlpc_mode_e  saved_mode_r;

   assign illegal_fetch = fetch_valid &&
                          ((fetch_addr <= `IVLPC_PERIPH_HI) ||
                           (fetch_addr >= `IVLPC_GAP_LO && fetch_addr <= `IVLPC_GAP_HI));
   assign reset_cause = ext_reset_event || watchdog_expire || flash_key_violation || illegal_fetch;

   assign nmi_req = (ext_nmi_flag && ext_nmi_enable) ||
                    (osc_fault_flag && osc_fault_enable) ||
                    (flash_access_violation_flag && flash_access_violation_enable);

   assign wdt_req = watchdog_flag && watchdog_irq_enable && watchdog_interval_mode;

   // Maskable sources by slot; grouped flags feed one slot each.
   always_comb begin
      mask_req = 16'h0000;
      mask_req[`IVLPC_SLOT_MAILBOX] = mailbox_out_flag || mailbox_in_flag;
      mask_req[`IVLPC_SLOT_CONV]    = converter_overflow_flag || converter_result_flag;
      mask_req[`IVLPC_SLOT_RX]      = serial_rx_flag;
      mask_req[`IVLPC_SLOT_TX]      = serial_tx_flag;
      mask_req[`IVLPC_SLOT_CMP]     = compare_match_flag;
      mask_req[`IVLPC_SLOT_TMR]     = timer_overflow_flag;
      mask_req[`IVLPC_SLOT_PORT1]   = |port_one_pin_flags;
      mask_req[`IVLPC_SLOT_PORT2]   = |port_two_pin_flags;
      mask_req[`IVLPC_SLOT_TICK]    = basic_tick_flag;
      mask_req = mask_req & slot_enable;
      mask_req[`IVLPC_SLOT_WDT]     = wdt_req;
      mask_req[`IVLPC_SLOT_NMI]     = 1'b0;
      mask_req[`IVLPC_SLOT_RESET]   = 1'b0;
   end

   // The global enable gates maskable slots only; the shared slot bypasses it.
   // bypass global enable
   always_comb begin
      slot_req = global_irq_enable ? mask_req : 16'h0000;
      slot_req[`IVLPC_SLOT_NMI] = nmi_req;
   end

   assign bus.slot_req = slot_req;
   assign bus.mode     = mode_r;

   ivlpc_prio u_prio (
      .mclk    (mclk),
      .rst_s_n (rst_s_n),
      .pif     (bus.prio_mp)
   );

   // ==========================================
   // Sequencer
   logic take;
   assign take          = (state_r == ST_IDLE) && bus.grant_valid && !reset_cause;
   assign vec_fetch_req = (state_r == ST_FETCH);

   // A reset cause beats everything and restarts through the reset vector.
   // reset vector
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         state_r <= ST_FETCH;
      end else if (reset_cause) begin
         state_r <= ST_FETCH;
      end else begin
         case (state_r)
            ST_IDLE:    if (take) state_r <= ST_FETCH;
            ST_FETCH:   if (vec_fetch_valid) state_r <= (vec_fetch_addr == `IVLPC_RESET_VEC) ? ST_IDLE
                                                                                            : ST_SERVICE;
            ST_SERVICE: if (irq_return) state_r <= ST_IDLE;
            default:    state_r <= ST_IDLE;
         endcase
      end
   end

   // Vector address is base plus twice the slot, always inside the table.
   // table range
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         vec_fetch_addr <= `IVLPC_RESET_VEC;
      end else if (reset_cause) begin
         vec_fetch_addr <= `IVLPC_RESET_VEC;
      end else if (take) begin
         vec_fetch_addr <= `IVLPC_VEC_BASE | {11'h000, bus.grant_slot, 1'b0};
      end
   end

   // Taken slot is reported once so single-source flags can be cleared.
   // others stay pending
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         taken_pulse <= 1'b0;
         taken_slot  <= 4'h0;
      end else begin
         taken_pulse <= take;
         if (take) taken_slot <= bus.grant_slot;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         pc_load  <= 1'b0;
         pc_value <= 16'h0000;
      end else begin
         pc_load <= vec_fetch_req && vec_fetch_valid && !reset_cause;
         if (vec_fetch_req && vec_fetch_valid) pc_value <= vec_fetch_data;
      end
   end

   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         sys_reset <= 1'b0;
      end else begin
         sys_reset <= reset_cause;
      end
   end

   // ==========================================
   // Mode control
   // The mode at interrupt entry is kept aside and put back on return.
   // Nesting is not supported: one saved mode is enough.
   // wake and restore
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         mode_r       <= full_run_mode;
         saved_mode_r <= full_run_mode;
      end else if (reset_cause) begin
         mode_r       <= full_run_mode;
         saved_mode_r <= full_run_mode;
      end else if (take) begin
         saved_mode_r <= mode_r;
         mode_r       <= full_run_mode;
      end else if (state_r == ST_SERVICE && irq_return) begin
         mode_r <= saved_mode_r;
      end else if (mode_wr) begin
         mode_r <= mode_sel;
      end
   end
   assign cur_mode = mode_r;

   ivlpc_lpm u_lpm (
      .mclk                 (mclk),
      .rst_s_n              (rst_s_n),
      .mif                  (bus.lpm_mp),
      .cpu_halt             (cpu_halt),
      .aclk_run             (aclk_run),
      .sub_main_clock_run   (sub_main_clock_run),
      .mclk_avail           (mclk_avail),
      .loop_ctrl_run        (loop_ctrl_run),
      .oscillator_clock_run (oscillator_clock_run),
      .dc_gen_on            (dc_gen_on),
      .xtal_run             (xtal_run)
   );

   // ==========================================
   // Checks
   property p_vec_range;
      @(posedge mclk) disable iff (!rst_s_n)
      vec_fetch_req |-> vec_fetch_addr >= `IVLPC_VEC_BASE && !vec_fetch_addr[0];
   endproperty
   a_vec_range: assert property (p_vec_range) else $error("vector outside table");

   property p_pc_load;
      @(posedge mclk) disable iff (!rst_s_n)
      vec_fetch_req && vec_fetch_valid && !reset_cause |=> pc_load && pc_value == $past(vec_fetch_data);
   endproperty
   a_pc_load: assert property (p_pc_load) else $error("vector word not loaded");

   property p_reset_vec;
      @(posedge mclk) disable iff (!rst_s_n)
      reset_cause |=> sys_reset && vec_fetch_req && vec_fetch_addr == `IVLPC_RESET_VEC;
   endproperty
   a_reset_vec: assert property (p_reset_vec) else $error("reset cause missed reset vector");

   property p_illegal;
      @(posedge mclk) disable iff (!rst_s_n)
      fetch_valid && (fetch_addr <= 16'h01FF || (fetch_addr >= 16'h0600 && fetch_addr <= 16'h0BFF)) |=> sys_reset;
   endproperty
   a_illegal: assert property (p_illegal) else $error("illegal fetch did not reset");

   property p_nmi;
      @(posedge mclk) disable iff (!rst_s_n)
      state_r == ST_IDLE && nmi_req && !reset_cause |=> vec_fetch_addr == 16'hFFFC ##1 vec_fetch_req[*1];
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi did not select shared vector");

   property p_gie;
      @(posedge mclk) disable iff (!rst_s_n)
      state_r == ST_IDLE && !global_irq_enable && !nmi_req && !reset_cause |=> state_r == ST_IDLE;
   endproperty
   a_gie: assert property (p_gie) else $error("maskable taken with global enable off");

   property p_wdt;
      @(posedge mclk) disable iff (!rst_s_n)
      !watchdog_interval_mode |-> !slot_req[`IVLPC_SLOT_WDT];
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog request in watchdog mode");

   property p_wake;
      @(posedge mclk) disable iff (!rst_s_n)
      take |=> mode_r == full_run_mode && saved_mode_r == $past(mode_r);
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not wake");

   property p_restore;
      @(posedge mclk) disable iff (!rst_s_n)
      state_r == ST_SERVICE && irq_return && !reset_cause |=> mode_r == $past(saved_mode_r) && state_r == ST_IDLE;
   endproperty
   a_restore: assert property (p_restore) else $error("mode not restored on return");
endmodule : ivlpc_top

// ===== pkg/ivlpc_cfg.svh
// Constants for the interrupt vector and low-power control block.
`ifndef IVLPC_CFG_SVH
`define IVLPC_CFG_SVH
// ==========================================
// Vector table
`define IVLPC_VEC_BASE      16'hFFE0
`define IVLPC_VEC_TOP       16'hFFFF
`define IVLPC_RESET_VEC     16'hFFFE
`define IVLPC_SLOT_RESET    4'hF
`define IVLPC_SLOT_NMI      4'hE
`define IVLPC_SLOT_MAILBOX  4'hD
`define IVLPC_SLOT_CONV     4'hC
`define IVLPC_SLOT_WDT      4'hA
`define IVLPC_SLOT_RX       4'h9
`define IVLPC_SLOT_TX       4'h8
`define IVLPC_SLOT_CMP      4'h6
`define IVLPC_SLOT_TMR      4'h5
`define IVLPC_SLOT_PORT1    4'h4
`define IVLPC_SLOT_PORT2    4'h1
`define IVLPC_SLOT_TICK     4'h0
// Slots with an assigned source; 11, 7, 3 and 2 are empty.
`define IVLPC_USED_SLOTS    16'hF773
// ==========================================
// Fetch ranges that force a reset
`define IVLPC_PERIPH_LO     16'h0000
`define IVLPC_PERIPH_HI     16'h01FF
`define IVLPC_GAP_LO        16'h0600
`define IVLPC_GAP_HI        16'h0BFF
`endif

// ===== pkg/ivlpc_pkg.sv
// Types shared by the interrupt vector and low-power control block.
package ivlpc_pkg;
   // ==========================================
   // Sequencer states, one-hot.
   typedef enum logic [2:0] {
      ST_IDLE    = 3'h1,
      ST_FETCH   = 3'h2,
      ST_SERVICE = 3'h4
   } ivlpc_state_e;
   // ==========================================
   // Operating modes selected by software.
   typedef enum logic [2:0] {
      full_run_mode   = 3'h0,
      low_power_zero  = 3'h1,
      low_power_one   = 3'h2,
      low_power_two   = 3'h3,
      low_power_three = 3'h4,
      low_power_four  = 3'h5
   } ivlpc_mode_e;
   typedef logic [3:0]  ivlpc_slot_t;
   typedef logic [15:0] ivlpc_word_t;
endpackage : ivlpc_pkg

// ===== pkg/ivlpc_if.sv
// Carrier between the sequencer, the priority encoder and the mode decoder.
`timescale 1ns/1ns
interface ivlpc_if;
   import ivlpc_pkg::*;
   logic [15:0] slot_req;
   logic        grant_valid;
   ivlpc_slot_t grant_slot;
   ivlpc_mode_e mode;
   modport top_mp  (output slot_req, output mode, input grant_valid, input grant_slot);
   modport prio_mp (input slot_req, output grant_valid, output grant_slot);
   modport lpm_mp  (input mode);
endinterface : ivlpc_if

// ===== src/ivlpc_prio.sv
// Fixed-priority encoder over the sixteen vector slots.
`timescale 1ns/1ns
`include "ivlpc_cfg.svh"
module ivlpc_prio (
   // Clock and synchronised reset
   input wire logic mclk,
   input wire logic rst_s_n,
   // Requests and grant
   ivlpc_if.prio_mp pif
);
   import ivlpc_pkg::*;
   localparam logic [15:0] USED = `IVLPC_USED_SLOTS;
   logic [15:0] eligible;

   // ==========================================
   // Eligibility
   // skip empty slots
   for (genvar i = 0; i < 16; i++) begin : g_elig
      assign eligible[i] = pif.slot_req[i] & USED[i];
   end

   // Highest slot wins; the rest stay pending at their sources.
   // higher vector ranks
   always_comb begin
      pif.grant_valid = 1'b0;
      pif.grant_slot  = 4'h0;
      for (int k = 0; k < 16; k++) begin
         if (eligible[k]) begin
            pif.grant_valid = 1'b1;
            pif.grant_slot  = 4'(k);
         end
      end
   end

   property p_skip_empty;
      @(posedge mclk) disable iff (!rst_s_n)
      pif.grant_valid |-> USED[pif.grant_slot] && pif.slot_req[pif.grant_slot];
   endproperty
   a_skip_empty: assert property (p_skip_empty) else $error("grant on empty or idle slot");
endmodule : ivlpc_prio

// ===== src/ivlpc_lpm.sv
// Clock and oscillator enables decoded from the operating mode.
`timescale 1ns/1ns
module ivlpc_lpm (
   // Clock and synchronised reset
   input  wire logic mclk,
   input  wire logic rst_s_n,
   // Mode in
   ivlpc_if.lpm_mp   mif,
   // Enables out
   output logic      cpu_halt,
   output logic      aclk_run,
   output logic      sub_main_clock_run,
   output logic      mclk_avail,
   output logic      loop_ctrl_run,
   output logic      oscillator_clock_run,
   output logic      dc_gen_on,
   output logic      xtal_run
);
   import ivlpc_pkg::*;
   logic [7:0] en_nxt;

   // ==========================================
   // Decode, packed as halt, aclk, sub_main_clock, mclk, loop, osc, dc, xtal.
   always_comb begin
      case (mif.mode)
         full_run_mode:   en_nxt = 8'h7F;
         low_power_zero:  en_nxt = 8'hFF;
         low_power_one:   en_nxt = 8'hF7;
         low_power_two:   en_nxt = 8'hC3;
         low_power_three: en_nxt = 8'hC1;
         low_power_four:  en_nxt = 8'h80;
         default:         en_nxt = 8'h7F;
      endcase
   end

   // Registered so the clock gates never see decode glitches.
   // active mode
   always_ff @(posedge mclk or negedge rst_s_n) begin
      if (!rst_s_n) begin
         {cpu_halt, aclk_run, sub_main_clock_run, mclk_avail,
          loop_ctrl_run, oscillator_clock_run, dc_gen_on, xtal_run} <= 8'h7F;
      end else begin
         {cpu_halt, aclk_run, sub_main_clock_run, mclk_avail,
          loop_ctrl_run, oscillator_clock_run, dc_gen_on, xtal_run} <= en_nxt;
      end
   end

   property p_low_power_four_stop;
      @(posedge mclk) disable iff (!rst_s_n)
      mif.mode == low_power_four |=> !aclk_run && !xtal_run && !dc_gen_on && cpu_halt;
   endproperty
   a_low_power_four_stop: assert property (p_low_power_four_stop) else $error("mode four left a clock running");
endmodule : ivlpc_lpm

// ===== tb/ivlpc_cpu_model.sv
// Behavioural CPU core that answers vector fetches after a chosen delay.
`timescale 1ns/1ns
module ivlpc_cpu_model (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   // Answer delay in cycles, two at the least
   input  wire logic [3:0]             lat,
   // Vector fetch
   input  wire logic                   vec_fetch_req,
   input  wire ivlpc_pkg::ivlpc_word_t vec_fetch_addr,
   output logic                        vec_fetch_valid,
   output ivlpc_pkg::ivlpc_word_t      vec_fetch_data
);
   import ivlpc_pkg::*;
   logic [3:0] cnt_r;
   // The handler address is the inverted vector address, so each slot gives its own word.
   // Outside the answer the data lines toggle, so a stale word is never mistaken for a fresh one.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r           <= 4'h0;
         vec_fetch_valid <= 1'b0;
         vec_fetch_data  <= 16'h5A5A;
      end else if (vec_fetch_valid) begin
         cnt_r           <= 4'h0;
         vec_fetch_valid <= 1'b0;
         vec_fetch_data  <= ~vec_fetch_data;
      end else if (vec_fetch_req && cnt_r >= lat) begin
         cnt_r           <= 4'h0;
         vec_fetch_valid <= 1'b1;
         vec_fetch_data  <= ~vec_fetch_addr;
      end else begin
         cnt_r           <= vec_fetch_req ? cnt_r + 4'h1 : 4'h0;
         vec_fetch_data  <= ~vec_fetch_data;
      end
   end
endmodule : ivlpc_cpu_model

// ===== tb/ivlpc_tb.sv
// Self-checking bench for the interrupt vector and low-power control block.
`timescale 1ns/1ns
module ivlpc_tb;
   import ivlpc_pkg::*;
   // ==========================================
   // Signals
   logic        mclk, rst_n, ext_reset_event, watchdog_expire, flash_key_violation, fetch_valid;
   logic        mode_wr, irq_return, gie, wdt_ie, wdt_iv, vec_fetch_valid, vec_fetch_req;
   logic        pc_load, taken_pulse, sys_reset;
   logic [2:0]  nmi_en;
   logic [14:0] src;
   logic [7:0]  pin;
   wire  [7:0]  en_o;
   logic [15:0] slot_enable;
   logic [3:0]  lat;
   ivlpc_word_t fetch_addr, vec_fetch_data, vec_fetch_addr, pc_value;
   ivlpc_slot_t taken_slot;
   ivlpc_mode_e mode_sel, cur_mode;
   int          miscompares = 0;
   int          checks_done = 0;
   int          cycles = 0;
   // Slot of each source bit, the order they must be served in, enables per mode, fetch addresses.
   localparam logic [3:0] SLOT [15] = '{4'hD, 4'hD, 4'hC, 4'hC, 4'hA, 4'h9, 4'h8, 4'h6,
                                        4'h5, 4'h4, 4'h1, 4'h0, 4'hE, 4'hE, 4'hE};
   localparam int ORD [15] = '{12, 13, 14, 0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11};
   localparam logic [7:0] EN [6] = '{8'h7F, 8'hFF, 8'hF7, 8'hC3, 8'hC1, 8'h80};
   localparam ivlpc_word_t FA [7] = '{16'h0000, 16'h01FF, 16'h0600, 16'h0BFF,
                                      16'h0200, 16'h05FF, 16'h0C00};
   // ==========================================
   // Design and CPU model
   ivlpc_top u_ivlpc_top (
      .mclk, .rst_n, .ext_reset_event, .watchdog_expire, .flash_key_violation, .fetch_valid, .fetch_addr,
      .ext_nmi_flag(src[12]), .osc_fault_flag(src[13]), .flash_access_violation_flag(src[14]),
      .ext_nmi_enable(nmi_en[0]), .osc_fault_enable(nmi_en[1]), .flash_access_violation_enable(nmi_en[2]),
      .mailbox_out_flag(src[0]), .mailbox_in_flag(src[1]), .converter_overflow_flag(src[2]),
      .converter_result_flag(src[3]), .watchdog_flag(src[4]), .serial_rx_flag(src[5]),
      .serial_tx_flag(src[6]), .compare_match_flag(src[7]), .timer_overflow_flag(src[8]),
      .port_one_pin_flags(src[9] ? pin : 8'h00), .port_two_pin_flags(src[10] ? ~pin : 8'h00),
      .basic_tick_flag(src[11]), .slot_enable, .watchdog_irq_enable(wdt_ie),
      .watchdog_interval_mode(wdt_iv), .global_irq_enable(gie), .mode_wr, .mode_sel, .irq_return,
      .vec_fetch_valid, .vec_fetch_data, .vec_fetch_req, .vec_fetch_addr, .pc_load, .pc_value,
      .taken_slot, .taken_pulse, .sys_reset, .cur_mode,
      .cpu_halt(en_o[7]), .aclk_run(en_o[6]), .sub_main_clock_run(en_o[5]), .mclk_avail(en_o[4]),
      .loop_ctrl_run(en_o[3]), .oscillator_clock_run(en_o[2]), .dc_gen_on(en_o[1]), .xtal_run(en_o[0]));
   ivlpc_cpu_model u_ivlpc_cpu_model (
      .mclk, .rst_n, .lat, .vec_fetch_req, .vec_fetch_addr, .vec_fetch_valid, .vec_fetch_data);
   // ==========================================
   // Clock and hang guard; the whole run needs a few hundred cycles.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         miscompares++;
         conclude();
      end
   end
   // ==========================================
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // Start vector fetch after any reset; the model hands back the inverted address.
   task automatic boot();
      repeat (30) if (vec_fetch_req !== 1'b1) @(negedge mclk);
      chk(vec_fetch_req, 1'b1);   // fetch restarted
      chk(vec_fetch_addr, 16'hFFFE);   // start vector
      repeat (30) if (pc_load !== 1'b1) @(negedge mclk);
      chk(pc_load, 1'b1);   // word taken
      chk(pc_value, 16'h0001);   // loaded word
      repeat (3) @(posedge mclk);
   endtask : boot
   task automatic set_mode(input ivlpc_mode_e m, input logic [7:0] e);
      @(posedge mclk);
      mode_wr  <= 1'b1;
      mode_sel <= m;
      @(posedge mclk);
      mode_wr <= 1'b0;
      @(negedge mclk);
      chk(cur_mode, m);   // mode taken
      @(negedge mclk);
      chk(en_o, e);   // clock enables
   endtask : set_mode
   task automatic rst_case(input logic [2:0] c, input ivlpc_word_t a, input logic e);
      @(posedge mclk);
      {ext_reset_event, watchdog_expire, flash_key_violation} <= c;
      fetch_valid <= (c == 3'h0);
      fetch_addr  <= a;
      @(posedge mclk);
      {ext_reset_event, watchdog_expire, flash_key_violation} <= 3'h0;
      fetch_valid <= 1'b0;
      @(negedge mclk);
      chk(sys_reset, e);   // reset raised
      if (e) begin
         chk(cur_mode, full_run_mode);   // mode cleared
         boot();
      end
   endtask : rst_case
   // Serves one pending slot, drops source k and returns to mode m.
   task automatic service(input ivlpc_slot_t s, input int k, input ivlpc_mode_e m);
      ivlpc_word_t va;
      va = 16'hFFE0 + {11'h000, s, 1'b0};
      repeat (30) if (vec_fetch_req !== 1'b1) @(negedge mclk);
      chk(vec_fetch_req, 1'b1);   // vector fetch asked
      chk(vec_fetch_addr, va);   // vector address
      chk(taken_slot, s);   // slot chosen
      chk(taken_pulse, 1'b1);   // one take
      chk(cur_mode, full_run_mode);   // woken
      repeat (30) if (pc_load !== 1'b1) @(negedge mclk);
      chk(pc_load, 1'b1);   // word taken
      chk(pc_value, ~va);   // handler address
      @(posedge mclk);
      src[k] <= 1'b0;
      repeat (3) @(posedge mclk);
      irq_return <= 1'b1;
      @(posedge mclk);
      irq_return <= 1'b0;
      @(negedge mclk);
      chk(cur_mode, m);   // mode restored
   endtask : service
   task automatic quiet();
      logic seen;
      seen = 1'b0;
      repeat (12) begin
         @(negedge mclk);
         seen |= (vec_fetch_req !== 1'b0);
      end
      chk(seen, 1'b0);   // nothing taken
   endtask : quiet
   // ==========================================
   // Main sequence
   initial begin
      rst_n = 1'b0;
      {ext_reset_event, watchdog_expire, flash_key_violation, fetch_valid} = 4'h0;
      {mode_wr, irq_return, gie, wdt_ie, wdt_iv} = 5'h00;
      nmi_en      = 3'h7;
      src         = 15'h0000;
      pin         = 8'h01;
      slot_enable = 16'hFFFF;
      lat         = 4'h2;
      fetch_addr  = 16'h0000;
      mode_sel    = full_run_mode;
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      boot();   // power-up vector
      for (int i = 0; i < 6; i++) set_mode(ivlpc_mode_e'(i), EN[i]);   // all modes
      // The first cause arrives in the deepest mode, which a reset must clear.
      rst_case(3'h4, 16'h0000, 1'b1);   // pin reset
      rst_case(3'h2, 16'h0000, 1'b1);   // watchdog expiry
      rst_case(3'h1, 16'h0000, 1'b1);   // key violation
      for (int i = 0; i < 7; i++) rst_case(3'h0, FA[i], i < 4);   // fetch range edges
      // Every source pending at once, with the empty slots enabled but never requested.
      set_mode(low_power_three, 8'hC1);   // mode three
      @(posedge mclk);
      gie    <= 1'b1;
      wdt_ie <= 1'b1;
      wdt_iv <= 1'b1;
      src    <= 15'h7FFF;
      for (int i = 0; i < 15; i++) service(SLOT[ORD[i]], ORD[i], low_power_three);   // order
      // Global enable holds maskable sources but not the shared vector.
      @(posedge mclk);
      gie    <= 1'b0;
      lat    <= 4'h7;
      src[5] <= 1'b1;
      quiet();   // global enable
      @(posedge mclk);
      src[12] <= 1'b1;
      service(4'hE, 12, low_power_three);   // past global enable
      quiet();   // maskable still held
      @(posedge mclk);
      src[5]  <= 1'b0;
      nmi_en  <= 3'h6;
      src[12] <= 1'b1;
      quiet();   // own enable
      // Watchdog request counts only in interval mode.
      @(posedge mclk);
      src[12] <= 1'b0;
      gie     <= 1'b1;
      wdt_iv  <= 1'b0;
      src[4]  <= 1'b1;
      quiet();   // watchdog mode
      @(posedge mclk);
      wdt_iv <= 1'b1;
      service(4'hA, 4, low_power_three);   // interval mode
      @(posedge mclk);
      slot_enable[9] <= 1'b0;
      src[5]         <= 1'b1;
      quiet();   // slot enable off
      conclude();
   end
endmodule : ivlpc_tb
